// ### urd_regs.svh
`ifndef URD_REGS_SVH
`define URD_REGS_SVH

// ==========================================================
// register locations on the three address lines
`define URD_ADDR_HOLD 3'h0
`define URD_ADDR_IE 3'h1
`define URD_ADDR_STAT 3'h2
`define URD_ADDR_LINE 3'h3
`define URD_ADDR_MODEM 3'h4
`define URD_ADDR_LSTAT 3'h5
`define URD_ADDR_MSTAT 3'h6
`define URD_ADDR_SCRATCH 3'h7

// ==========================================================
// access keys and steering bits
`define URD_ENH_KEY 8'hbf
`define URD_DIV_BIT 7
`define URD_ENH_BIT 4
`define URD_PAGE_BIT 6
`define URD_DIV_ZERO 8'h00

// ==========================================================
// writable and enhanced bit masks
`define URD_IE_WR_MASK 8'h3f
`define URD_IE_ENH_MASK 8'hf0
`define URD_FIFO_ENH_MASK 8'h30
`define URD_STAT_ENH_MASK 6'h30
`define URD_MC_WR_MASK 8'hfb
`define URD_MC_ENH_MASK 8'he0
`define URD_FRAC_MASK 8'h0f
`define URD_MODE_WR_MASK 8'hf3
`define URD_EF_WR_MASK 8'h3f

// ==========================================================
// reset values and interrupt source codes
`define URD_RST_BYTE 8'h00
`define URD_INT_NONE 6'h01
`define URD_INT_LINE 6'h06
`define URD_INT_RXD 6'h04
`define URD_INT_TXE 6'h02
`define URD_INT_MODEM 6'h00
`define URD_INT_XOFF 6'h10

`endif

// ### urd_pkg.sv
package urd_pkg;
  typedef enum logic [4:0] {
    sel_rx_hold, sel_tx_hold, sel_div_low, sel_div_high, sel_div_frac,
    sel_rev_code, sel_id_code, sel_int_enable, sel_int_status, sel_fifo_ctl,
    sel_line_ctl, sel_modem_ctl, sel_line_stat, sel_modem_stat, sel_scratch,
    sel_level, sel_mode_sel, sel_trigger, sel_feature, sel_enh_func,
    sel_resume_one, sel_resume_two, sel_pause_one, sel_pause_two, sel_none
  } urd_sel_t;
endpackage

// ### urd_sync.sv
module urd_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// ### urd_fifo.sv
module urd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH) + 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_q];

  always_comb begin
    count_d = count;
    if (flush) begin
      count_d = '0;
    end else if (push && !pop) begin
      count_d = count + CW'(1);
    end else if (pop && !push) begin
      count_d = count - CW'(1);
    end
  end

  // ready and valid are registered so the top drives them straight from flops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count <= count_d;
      in_ready <= count_d != CW'(DEPTH);
      out_valid <= count_d != '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + PW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push && !flush) begin
      mem[wr_ptr_q] <= in_data;
    end
  end
endmodule

// ### urd_top.sv
`include "urd_regs.svh"

module urd_top
  import urd_pkg::*;
#(
  parameter logic [7:0] REV_CODE = 8'h11,
  parameter logic [7:0] ID_CODE = 8'h22
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_byte_q,
  output logic tx_load_q,
  input wire logic [5:0] tx_level,
  input wire logic [7:1] line_flags,
  input wire logic xoff_seen,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic dtr_n_q,
  output logic rts_n_q,
  output logic [15:0] divisor_q,
  output logic [3:0] div_fraction_q,
  output logic [7:0] line_control_q,
  output logic [7:0] fifo_control_q,
  output logic [7:0] modem_control_q,
  output logic [7:0] int_enable_q,
  output logic [7:0] feature_control_q,
  output logic [7:0] enhanced_function_q,
  output logic [7:0] mode_select_q,
  output logic [7:0] trigger_level_q,
  output logic trigger_load_q,
  output logic [7:0] resume_one_q,
  output logic [7:0] resume_two_q,
  output logic [7:0] pause_one_q,
  output logic [7:0] pause_two_q,
  output logic rx_fifo_flush_q,
  output logic tx_fifo_flush_q
);
  // ==========================================================
  // decode
  function automatic urd_sel_t decode(input logic [2:0] a, input logic rd,
                                      input logic [7:0] lc, input logic enh,
                                      input logic page, input logic div_zero);
    urd_sel_t s;
    logic dv;
    s = sel_none;
    dv = lc[`URD_DIV_BIT];
    if (lc == `URD_ENH_KEY) begin
      case (a)
        `URD_ADDR_HOLD: s = rd ? sel_level : sel_trigger;
        `URD_ADDR_IE: s = sel_feature;
        `URD_ADDR_STAT: s = sel_enh_func;
        `URD_ADDR_LINE: s = sel_line_ctl;
        `URD_ADDR_MODEM: s = sel_resume_one;
        `URD_ADDR_LSTAT: s = sel_resume_two;
        `URD_ADDR_MSTAT: s = sel_pause_one;
        default: s = sel_pause_two;
      endcase
    end else begin
      case (a)
        `URD_ADDR_HOLD: begin
          if (dv) begin
            s = (rd && div_zero) ? sel_rev_code : sel_div_low;
          end else begin
            s = rd ? sel_rx_hold : sel_tx_hold;
          end
        end
        `URD_ADDR_IE: begin
          if (dv) begin
            s = (rd && div_zero) ? sel_id_code : sel_div_high;
          end else begin
            s = sel_int_enable;
          end
        end
        `URD_ADDR_STAT: begin
          if (dv && enh) begin
            s = sel_div_frac;
          end else begin
            s = rd ? sel_int_status : sel_fifo_ctl;
          end
        end
        `URD_ADDR_LINE: s = sel_line_ctl;
        `URD_ADDR_MODEM: s = sel_modem_ctl;
        `URD_ADDR_LSTAT: s = rd ? sel_line_stat : sel_none;
        `URD_ADDR_MSTAT: s = rd ? sel_modem_stat : sel_none;
        default: begin
          if (page) begin
            s = rd ? sel_level : sel_mode_sel;
          end else begin
            s = sel_scratch;
          end
        end
      endcase
    end
    return s;
  endfunction

  // ==========================================================
  // pin synchronisers and strobe edges
  // address and data pass the same two flops as the strobes, so they must
  // be stable at least two clocks before the strobe goes active
  logic [13:0] bus_s;
  logic [3:0] modem_s;
  logic act_cs;
  logic rd_act;
  logic wr_act;
  logic rd_prev_q;
  logic wr_prev_q;
  logic rd_go;
  logic wr_go;
  logic [2:0] a_s;
  logic [7:0] d_s;

  urd_sync #(.WIDTH(14), .RST_VAL(14'h3800)) u_bus_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d_in({cs_n, rd_n, wr_n, addr, data_in}),
    .q_out(bus_s)
  );

  urd_sync #(.WIDTH(4), .RST_VAL(4'hf)) u_modem_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d_in({cd_n, ri_n, dsr_n, cts_n}),
    .q_out(modem_s)
  );

  assign act_cs = ~bus_s[13];
  assign rd_act = act_cs & ~bus_s[12];
  assign wr_act = act_cs & ~bus_s[11];
  assign a_s = bus_s[10:8];
  assign d_s = bus_s[7:0];
  assign rd_go = rd_act & ~rd_prev_q;
  assign wr_go = wr_act & ~wr_prev_q & ~rd_act;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      data_oe <= 1'b0;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
      data_oe <= rd_act;
    end
  end

  // ==========================================================
  // shared state
  logic enh;
  logic div_zero;
  urd_sel_t rd_sel;
  urd_sel_t wr_sel;
  logic [7:0] scratch_q;
  logic [3:0] delta_q;
  logic [3:0] level_prev_q;
  logic [3:0] level_now;
  logic [5:0] rx_count;
  logic [7:0] rx_head;
  logic rx_has;
  logic rx_pop_q;
  logic [7:0] fifo_level;
  logic [5:0] int_src;
  logic [7:0] rd_val;

  assign enh = enhanced_function_q[`URD_ENH_BIT];
  assign div_zero = divisor_q == {`URD_DIV_ZERO, `URD_DIV_ZERO};
  assign rd_sel = decode(a_s, 1'b1, line_control_q, enh,
                         feature_control_q[`URD_PAGE_BIT], div_zero);
  assign wr_sel = decode(a_s, 1'b0, line_control_q, enh,
                         feature_control_q[`URD_PAGE_BIT], div_zero);
  assign level_now = ~modem_s;
  // mode select bit 0 picks the transmit count, otherwise the receive count
  assign fifo_level = mode_select_q[0] ? {2'h0, tx_level} : {2'h0, rx_count};

  // ==========================================================
  // receive fifo
  urd_fifo #(.WIDTH(8), .DEPTH(32)) u_rx_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(rx_fifo_flush_q),
    .in_valid(rx_valid),
    .in_data(rx_byte),
    .in_ready(rx_ready),
    .out_valid(rx_has),
    .out_ready(rx_pop_q),
    .out_data(rx_head),
    .count(rx_count)
  );

  // ==========================================================
  // interrupt source, highest priority first
  always_comb begin
    int_src = `URD_INT_NONE;
    if (int_enable_q[2] && (|line_flags[4:1] || line_flags[7])) begin
      int_src = `URD_INT_LINE;
    end else if (int_enable_q[0] && rx_has) begin
      int_src = `URD_INT_RXD;
    end else if (int_enable_q[1] && line_flags[5]) begin
      int_src = `URD_INT_TXE;
    end else if (int_enable_q[3] && |delta_q) begin
      int_src = `URD_INT_MODEM;
    end else if (int_enable_q[5] && xoff_seen) begin
      int_src = `URD_INT_XOFF;
    end
    if (!enh) begin
      int_src = int_src & ~`URD_STAT_ENH_MASK;
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    case (rd_sel)
      sel_rx_hold: rd_val = rx_head;
      sel_div_low: rd_val = divisor_q[7:0];
      sel_div_high: rd_val = divisor_q[15:8];
      sel_div_frac: rd_val = {4'h0, div_fraction_q};
      sel_rev_code: rd_val = REV_CODE;
      sel_id_code: rd_val = ID_CODE;
      sel_int_enable: rd_val = int_enable_q & (enh ? 8'hff : ~`URD_IE_ENH_MASK);
      sel_int_status: rd_val = {{2{fifo_control_q[0]}}, int_src};
      sel_line_ctl: rd_val = line_control_q;
      sel_modem_ctl: rd_val = modem_control_q & (enh ? 8'hff : ~`URD_MC_ENH_MASK);
      sel_line_stat: rd_val = {line_flags, rx_has};
      sel_modem_stat: rd_val = {level_now, delta_q};
      sel_scratch: rd_val = scratch_q;
      sel_level: rd_val = fifo_level;
      sel_feature: rd_val = feature_control_q;
      sel_enh_func: rd_val = enhanced_function_q;
      sel_resume_one: rd_val = resume_one_q;
      sel_resume_two: rd_val = resume_two_q;
      sel_pause_one: rd_val = pause_one_q;
      sel_pause_two: rd_val = pause_two_q;
      default: rd_val = `URD_RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_out <= `URD_RST_BYTE;
      rx_pop_q <= 1'b0;
    end else begin
      rx_pop_q <= rd_go && rd_sel == sel_rx_hold && rx_has;
      if (rd_go) begin
        data_out <= rd_val;
      end
    end
  end

  // ==========================================================
  // standard configuration registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      divisor_q <= {`URD_RST_BYTE, `URD_RST_BYTE};
      div_fraction_q <= 4'h0;
      line_control_q <= `URD_RST_BYTE;
      int_enable_q <= `URD_RST_BYTE;
      fifo_control_q <= `URD_RST_BYTE;
      modem_control_q <= `URD_RST_BYTE;
      scratch_q <= `URD_RST_BYTE;
      mode_select_q <= `URD_RST_BYTE;
      dtr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
    end else if (wr_go) begin
      case (wr_sel)
        sel_div_low: divisor_q[7:0] <= d_s;
        sel_div_high: divisor_q[15:8] <= d_s;
        sel_div_frac: div_fraction_q <= d_s[3:0];
        sel_line_ctl: line_control_q <= d_s;
        sel_int_enable: begin
          int_enable_q <= d_s & (enh ? `URD_IE_WR_MASK
                                     : (`URD_IE_WR_MASK & ~`URD_IE_ENH_MASK));
        end
        sel_fifo_ctl: begin
          // the two reset bits act as pulses and are not kept
          fifo_control_q <= d_s & ~8'h06 & (enh ? 8'hff : ~`URD_FIFO_ENH_MASK);
        end
        sel_modem_ctl: begin
          modem_control_q <= d_s & `URD_MC_WR_MASK
                             & (enh ? 8'hff : ~`URD_MC_ENH_MASK);
          dtr_n_q <= ~d_s[0];
          rts_n_q <= ~d_s[1];
        end
        sel_scratch: scratch_q <= d_s;
        sel_mode_sel: mode_select_q <= d_s & `URD_MODE_WR_MASK;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // enhanced page registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      feature_control_q <= `URD_RST_BYTE;
      enhanced_function_q <= `URD_RST_BYTE;
      trigger_level_q <= `URD_RST_BYTE;
      resume_one_q <= `URD_RST_BYTE;
      resume_two_q <= `URD_RST_BYTE;
      pause_one_q <= `URD_RST_BYTE;
      pause_two_q <= `URD_RST_BYTE;
    end else if (wr_go) begin
      case (wr_sel)
        sel_feature: feature_control_q <= d_s;
        sel_enh_func: enhanced_function_q <= d_s & `URD_EF_WR_MASK;
        sel_trigger: trigger_level_q <= d_s;
        sel_resume_one: resume_one_q <= d_s;
        sel_resume_two: resume_two_q <= d_s;
        sel_pause_one: pause_one_q <= d_s;
        sel_pause_two: pause_two_q <= d_s;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // one-cycle strobes toward the serial engines
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_byte_q <= `URD_RST_BYTE;
      tx_load_q <= 1'b0;
      trigger_load_q <= 1'b0;
      rx_fifo_flush_q <= 1'b0;
      tx_fifo_flush_q <= 1'b0;
    end else begin
      tx_load_q <= wr_go && wr_sel == sel_tx_hold;
      trigger_load_q <= wr_go && wr_sel == sel_trigger;
      rx_fifo_flush_q <= wr_go && wr_sel == sel_fifo_ctl && d_s[1];
      tx_fifo_flush_q <= wr_go && wr_sel == sel_fifo_ctl && d_s[2];
      if (wr_go && wr_sel == sel_tx_hold) begin
        tx_byte_q <= d_s;
      end
    end
  end

  // ==========================================================
  // modem input change flags
  // a change in the same cycle as the clearing read survives the clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      level_prev_q <= 4'h0;
      delta_q <= 4'h0;
    end else begin
      level_prev_q <= level_now;
      if (rd_go && rd_sel == sel_modem_stat) begin
        delta_q <= level_now ^ level_prev_q;
      end else begin
        delta_q <= delta_q | (level_now ^ level_prev_q);
      end
    end
  end
endmodule

// ### urd_host.sv
module urd_host (
  input wire logic clk_sys,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] addr,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
    data_in = 8'h00;
  end

  // ==========
  // bus cycles
  // released lines show the inverse, so a stale value never looks valid
  task automatic drop_bus(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cs_n = 1'b1;
    addr = ~a;
    data_in = ~d;
    repeat (3) @(negedge clk_sys);
  endtask

  // address and data lead the strobe by two clocks because the pins are synchronised
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sel);
    @(negedge clk_sys);
    addr = a;
    data_in = d;
    cs_n = ~sel;
    repeat (2) @(negedge clk_sys);
    wr_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    wr_n = 1'b1;
    drop_bus(a, d);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    bit seen;
    seen = 1'b0;
    d = 'x;
    @(negedge clk_sys);
    addr = a;
    cs_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rd_n = 1'b0;
    for (int n = 0; n < 8 && !seen; n++) begin
      @(posedge clk_sys);
      #1;
      seen = (data_oe === 1'b1);
      if (seen) d = data_out;
    end
    @(negedge clk_sys);
    rd_n = 1'b1;
    drop_bus(a, data_in);
  endtask
endmodule

// ### urd_top_sva.sv
module urd_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  input wire logic data_oe,
  input wire logic tx_load_q,
  input wire logic dtr_n_q,
  input wire logic rts_n_q,
  input wire logic [7:0] line_control_q,
  input wire logic [7:0] int_enable_q,
  input wire logic [7:0] modem_control_q,
  input wire logic [7:0] fifo_control_q,
  input wire logic [7:0] enhanced_function_q,
  input wire logic rx_fifo_flush_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // ==========
  // strobes as seen on the pins
  sequence rd_take;
    !cs_n && $fell(rd_n);
  endsequence

  sequence wr_take(logic [2:0] a);
    !cs_n && $fell(wr_n) && addr == a;
  endsequence

  rd_answer_a: assert property (rd_take |-> ##[2:4] data_oe)
    else $error("read strobe got no data enable");
  oe_cause_a: assert property (
    $rose(data_oe) |-> !$past(cs_n, 2) && !$past(rd_n, 2))
    else $error("data enable without a selected read");
  lc_write_a: assert property (
    wr_take(3'h3) |-> ##[2:4] line_control_q == data_in)
    else $error("line control not loaded from the bus");
  tx_load_a: assert property (
    tx_load_q |-> (!line_control_q[7] && addr == 3'h0 && !cs_n && !wr_n) ##1 !tx_load_q)
    else $error("transmit load without a holding write");
  resv_bits_a: assert property (
    int_enable_q[7:6] == 2'b00 && modem_control_q[2] == 1'b0)
    else $error("reserved bit stored");
  // enhanced fields may not turn on while the unlock bit was clear
  enh_lock_a: assert property (
    !$past(enhanced_function_q[4]) |->
      ((int_enable_q & ~$past(int_enable_q) & 8'hf0) == 8'h00) &&
      ((modem_control_q & ~$past(modem_control_q) & 8'he0) == 8'h00) &&
      ((fifo_control_q & ~$past(fifo_control_q) & 8'h30) == 8'h00))
    else $error("enhanced bit set while locked");
  fc_pulse_a: assert property (
    rx_fifo_flush_q |-> fifo_control_q[2:1] == 2'b00 ##1 !rx_fifo_flush_q)
    else $error("fifo reset not a single pulse");
  handshake_a: assert property (
    dtr_n_q == !modem_control_q[0] && rts_n_q == !modem_control_q[1])
    else $error("handshake outputs differ from modem control");
endmodule

bind urd_top urd_sva chk_u (
  .clk_sys, .sys_rst, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_oe, .tx_load_q,
  .dtr_n_q, .rts_n_q, .line_control_q, .int_enable_q, .modem_control_q,
  .fifo_control_q, .enhanced_function_q, .rx_fifo_flush_q
);

// ### tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] lc;
    logic [2:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } urd_row_t;
  localparam logic [7:0] REV = 8'h5c; // arbitrary value
  localparam logic [7:0] IDC = 8'h3e; // arbitrary value
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cs_n, rd_n, wr_n, data_oe, rx_ready, tx_load_q, dtr_n_q, rdy;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, tx_byte_q, fifo_control_q, mode_select_q, got, tx_last;
  logic [7:0] trigger_level_q;
  logic [7:0] rx_byte = 8'h00;
  logic rx_valid = 1'b0;
  logic xoff_seen = 1'b0;
  logic cts_n = 1'b1, dsr_n = 1'b1, ri_n = 1'b1, cd_n = 1'b1;
  logic [5:0] tx_level = 6'h05;
  logic [7:1] line_flags = 7'h30;
  int failures = 0, num_checks = 0, tx_cnt = 0, n;
  urd_row_t rows [15] = '{
    '{8'h03, 3'h7, 8'ha5, 8'ha5},
    '{8'h1b, 3'h3, 8'h1b, 8'h1b},
    '{8'h03, 3'h1, 8'hff, 8'h0f},
    '{8'h83, 3'h0, 8'h34, 8'h34},
    '{8'h83, 3'h1, 8'h12, 8'h12},
    '{8'hbf, 3'h1, 8'h05, 8'h05},
    '{8'hbf, 3'h2, 8'h10, 8'h10},
    '{8'hbf, 3'h4, 8'h11, 8'h11},
    '{8'hbf, 3'h5, 8'h13, 8'h13},
    '{8'hbf, 3'h6, 8'h22, 8'h22},
    '{8'hbf, 3'h7, 8'h24, 8'h24},
    '{8'h03, 3'h1, 8'hff, 8'h3f},
    '{8'h03, 3'h4, 8'hff, 8'hfb},
    '{8'h83, 3'h2, 8'hff, 8'h0f},
    '{8'h03, 3'h5, 8'haa, 8'h60}
  };

  always #12.5 clk_sys = ~clk_sys;

  urd_top #(.REV_CODE(REV), .ID_CODE(IDC)) dut_u (
    .clk_sys, .sys_rst, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe,
    .rx_byte, .rx_valid, .rx_ready, .tx_byte_q, .tx_load_q, .tx_level, .line_flags,
    .xoff_seen, .cts_n, .dsr_n, .ri_n, .cd_n, .dtr_n_q, .rts_n_q(), .divisor_q(),
    .div_fraction_q(), .line_control_q(), .fifo_control_q, .modem_control_q(),
    .int_enable_q(), .feature_control_q(), .enhanced_function_q(), .mode_select_q,
    .trigger_level_q, .trigger_load_q(), .resume_one_q(), .resume_two_q(),
    .pause_one_q(), .pause_two_q(), .rx_fifo_flush_q(), .tx_fifo_flush_q()
  );

  urd_host host_u (.clk_sys, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe);

  always @(posedge clk_sys) begin
    if (tx_load_q === 1'b1) begin
      tx_cnt <= tx_cnt + 1;
      tx_last <= tx_byte_q;
    end
  end

  // ==========
  // checking and closing
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string nm);
    host_u.rd(a, got);
    chk(nm, got, e);
  endtask

  task automatic set_line(input logic [7:0] v);
    host_u.wr(3'h3, v, 1'b1);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end

  // ==========
  // main sequence
  initial begin
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("dtr reset", {7'h00, dtr_n_q}, 8'h01);
    rd_chk(3'h3, 8'h00, "line reset");
    foreach (rows[i]) begin
      set_line(rows[i].lc);
      host_u.wr(rows[i].a, rows[i].w, 1'b1);
      rd_chk(rows[i].a, rows[i].e, $sformatf("row %0d", i));
    end
    chk("dtr on", {7'h00, dtr_n_q}, 8'h00);
    host_u.wr(3'h7, 8'h5a, 1'b0);
    rd_chk(3'h7, 8'ha5, "unselected");
    host_u.wr(3'h0, 8'h5a, 1'b1);
    chk("tx count", 8'(tx_cnt), 8'h01);
    chk("tx byte", tx_last, 8'h5a);
    host_u.wr(3'h4, 8'h00, 1'b1);
    // fill the receive buffer until it refuses
    rx_valid = 1'b1;
    n = 0;
    repeat (40) begin
      rx_byte = 8'(n);
      rdy = rx_ready;
      @(negedge clk_sys);
      if (rdy === 1'b1) n++;
    end
    rx_valid = 1'b0;
    chk("fill", 8'(n), 8'h20);
    chk("ready", {7'h00, rx_ready}, 8'h00);
    set_line(8'hbf);
    rd_chk(3'h0, 8'h20, "level");
    set_line(8'h03);
    for (int k = 0; k < 32; k++) rd_chk(3'h0, 8'(k), "rx byte");
    host_u.wr(3'h2, 8'h07, 1'b1);
    chk("fifo ctl", fifo_control_q, 8'h01);
    rd_chk(3'h2, 8'hc2, "status");
    line_flags = 7'h31;
    rd_chk(3'h2, 8'hc6, "line error");
    rd_chk(3'h5, 8'h62, "line flags");
    line_flags = 7'h30;
    set_line(8'hbf);
    host_u.wr(3'h1, 8'h45, 1'b1);
    host_u.wr(3'h0, 8'h2c, 1'b1);
    chk("trigger", trigger_level_q, 8'h2c);
    set_line(8'h03);
    host_u.wr(3'h7, 8'hff, 1'b1);
    chk("mode sel", mode_select_q, 8'hf3);
    rd_chk(3'h7, 8'h05, "tx level");
    set_line(8'h83);
    host_u.wr(3'h0, 8'h00, 1'b1);
    host_u.wr(3'h1, 8'h00, 1'b1);
    rd_chk(3'h0, REV, "revision");
    rd_chk(3'h1, IDC, "identity");
    cts_n = 1'b0;
    ri_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    rd_chk(3'h6, 8'h55, "modem delta");
    rd_chk(3'h6, 8'h50, "modem level");
    // stored enhanced enable bits must read as zero once the unlock is cleared
    set_line(8'hbf);
    host_u.wr(3'h2, 8'h00, 1'b1);
    set_line(8'h03);
    rd_chk(3'h1, 8'h0f, "ie locked");
    sys_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("mode reset", mode_select_q, 8'h00);
    rd_chk(3'h3, 8'h00, "line again");
    wrap_up();
  end
endmodule
